// file: hdl/pin_mux_pkg.sv
// Constants for the serial and bus pin function select block
// What this block does
// - Serial clock pin: input if select 1 and direction 0; drives clock if select 0.
// - In asynchronous character mode the serial clock pin becomes a plain port pin.
// - Serial clock and flow pins are taken only while serial operation is enabled.
// - Port pins drive their latch when direction is 1, else act as input.
// - Input pins pulled high only when group pull-up bit is 1; outputs never.
// - Flow pin, disable 0: select 1 drives request, select 0 with direction 0 accepts clear.
// - Latch, hold request, hold acknowledge and read strobe own pins when mode bit0 is 1.
// - Bus clock pin drives bus clock when mode bit0 is 1 and disable bit 0.
// - Upper-byte pin: byte-high enable when strobe mode 0, upper write strobe when 1.
// - Lower write pin: single write strobe when strobe mode 0, lower strobe when 1.
// - Chip selects three and two drive pins when mode bit0 and enable bits are 1.
`default_nettype none
package pin_mux_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;
   localparam int NUM_PINS = 12;
   localparam logic [ADDR_W-1:0] OFS_PROC_MODE   = 10'h004;
   localparam logic [ADDR_W-1:0] OFS_SYS_CLOCK   = 10'h006;
   localparam logic [ADDR_W-1:0] OFS_CHIP_SELECT = 10'h008;
   localparam logic [ADDR_W-1:0] OFS_SER_MODE    = 10'h3a0;
   localparam logic [ADDR_W-1:0] OFS_SER_CTRL    = 10'h3a4;
   localparam logic [ADDR_W-1:0] OFS_P4_DATA     = 10'h3e8;
   localparam logic [ADDR_W-1:0] OFS_P5_DATA     = 10'h3e9;
   localparam logic [ADDR_W-1:0] OFS_P4_DIR      = 10'h3ea;
   localparam logic [ADDR_W-1:0] OFS_P5_DIR      = 10'h3eb;
   localparam logic [ADDR_W-1:0] OFS_P6_DATA     = 10'h3ec;
   localparam logic [ADDR_W-1:0] OFS_P6_DIR      = 10'h3ee;
   localparam logic [ADDR_W-1:0] OFS_PULLUP      = 10'h3fd;
   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
   // Field positions
   localparam int PM_MODE_LO = 0;
   localparam int PM_MODE_HI = 1;
   localparam int PM_WR_MODE = 2;
   localparam int PM_BUSCLK_OFF = 7;
   localparam int CSC_TWO = 2;
   localparam int CSC_THREE = 3;
   localparam int SM_MODE_HI = 2;
   localparam int SM_ASYNC = 2;
   localparam int SM_CLK_EXT = 3;
   localparam int SC_FLOW_SEL = 2;
   localparam int SC_FLOW_OFF = 4;
   localparam int SCC_OUT_LO = 0;
   localparam int SCC_OUT_HI = 1;
   localparam int PU_P44 = 1;
   localparam int PU_P50 = 2;
   localparam int PU_P54 = 3;
   localparam int PU_P60 = 4;
   // Pin slots: 0..1 port4 bits 6..7, 2..9 port5 bits 0..7, 10..11 port6 bits 0..1
   localparam int PIN_SELECT_TWO = 0;
   localparam int PIN_SELECT_THREE = 1;
   localparam int PIN_LOW_WRITE = 2;
   localparam int PIN_UPPER_BYTE = 3;
   localparam int PIN_READ = 4;
   localparam int PIN_BUS_CLOCK = 5;
   localparam int PIN_HOLD_ACK = 6;
   localparam int PIN_HOLD_REQ = 7;
   localparam int PIN_ADDR_LATCH = 8;
   localparam int PIN_CLOCK_OUT = 9;
   localparam int PIN_FLOW = 10;
   localparam int PIN_SER_CLOCK = 11;
endpackage
`default_nettype wire

// file: hdl/pin_input_sync.sv
// Three-stage input synchroniser that accepts a level once two stages agree
`default_nettype none
module pin_input_sync #(
   parameter int WIDTH = 12
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] level
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;
   logic [WIDTH-1:0] next_level;

   always_comb begin
      next_level = level;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2[i] == s3[i]) begin
            next_level[i] = s3[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta  <= '0;
         s2    <= '0;
         s3    <= '0;
         level <= '0;
      end else begin
         meta  <= async_in;
         s2    <= meta;
         s3    <= s2;
         level <= next_level;
      end
   end
endmodule
`default_nettype wire

// file: hdl/pin_cell.sv
// One pin: peripheral function or general port with gated pull-up
`default_nettype none
module pin_cell (
   input  wire logic dir,
   input  wire logic latch,
   input  wire logic pullup_bit,
   input  wire logic take,
   input  wire logic per_oe,
   input  wire logic per_out,
   output logic      out,
   output logic      oe,
   output logic      pull
);
   always_comb begin
      if (take) begin
         oe  = per_oe;
         out = per_out;
      end else begin
         oe  = dir;
         out = latch;
      end
      // A driven pin never gets the pull-up
      pull = pullup_bit & ~oe;
   end
endmodule
`default_nettype wire

// file: hdl/pin_function_select.sv
// Pin function select for the serial channel 0 and external bus control pins
//
// Chosen here: strobed register access.
`default_nettype none
module pin_function_select (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [9:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        serial0_clock_internal,
   input  wire logic        serial0_request_to_send,
   input  wire logic        bus_clock,
   input  wire logic        address_latch,
   input  wire logic        bus_hold_acknowledge,
   input  wire logic        read_strobe,
   input  wire logic        byte_high_enable,
   input  wire logic        upper_byte_write_strobe,
   input  wire logic        single_write_strobe,
   input  wire logic        lower_byte_write_strobe,
   input  wire logic        chip_select_three,
   input  wire logic        chip_select_two,
   input  wire logic        clock_output_source,
   input  wire logic [11:0] pad_in,
   output logic      [11:0] pad_out,
   output logic      [11:0] pad_oe,
   output logic      [11:0] pad_pullup,
   output logic             serial0_clock_external,
   output logic             serial0_clear_to_send,
   output logic             hold_request,
   output logic             bus_ready
);
   localparam int N = pin_mux_pkg::NUM_PINS;

   logic [7:0] processor_mode_0;
   logic [7:0] system_clock_control_0;
   logic [7:0] chip_select_control;
   logic [7:0] serial0_mode;
   logic [7:0] serial0_control_0;
   logic [7:0] port4_direction;
   logic [7:0] port5_direction;
   logic [7:0] port6_direction;
   logic [7:0] pullup_control_1;
   logic [7:0] port4_data;
   logic [7:0] port5_data;
   logic [7:0] port6_data;

   logic [7:0] next_processor_mode_0;
   logic [7:0] next_system_clock_control_0;
   logic [7:0] next_chip_select_control;
   logic [7:0] next_serial0_mode;
   logic [7:0] next_serial0_control_0;
   logic [7:0] next_port4_direction;
   logic [7:0] next_port5_direction;
   logic [7:0] next_port6_direction;
   logic [7:0] next_pullup_control_1;
   logic [7:0] next_port4_data;
   logic [7:0] next_port5_data;
   logic [7:0] next_port6_data;
   logic [7:0] next_reg_rdata;

   logic [N-1:0] pin_level;
   logic [N-1:0] dir_v;
   logic [N-1:0] latch_v;
   logic [N-1:0] pu_v;
   logic [N-1:0] take;
   logic [N-1:0] per_oe;
   logic [N-1:0] per_out;
   logic [N-1:0] cell_out;
   logic [N-1:0] cell_oe;
   logic [N-1:0] cell_pull;
   logic [N-1:0] read_v;

   logic ext_bus;
   logic gp_mode;
   logic ser_on;
   logic ser_async;
   logic ser_clk_ext;
   logic flow_on;
   logic clk_in_fn;
   logic flow_in_fn;
   logic next_clock_external;
   logic next_clear_to_send;
   logic next_hold_request;
   logic next_bus_ready;

   pin_input_sync #(
      .WIDTH(N)
   ) u_sync (
      .clk     (clk),
      .rst_n   (rst_n),
      .async_in(pad_in),
      .level   (pin_level)
   );

   // Per-pin views of direction, latch and pull-up group
   assign dir_v = {port6_direction[1:0], port5_direction, port4_direction[7:6]};
   assign latch_v = {port6_data[1:0], port5_data, port4_data[7:6]};
   assign pu_v = {{2{pullup_control_1[pin_mux_pkg::PU_P60]}},
                  {4{pullup_control_1[pin_mux_pkg::PU_P54]}},
                  {4{pullup_control_1[pin_mux_pkg::PU_P50]}},
                  {2{pullup_control_1[pin_mux_pkg::PU_P44]}}};
   // Port reads show the pin for inputs and the latch for outputs
   assign read_v = (latch_v & dir_v) | (pin_level & ~dir_v);

   // Register file
   always_comb begin
      next_processor_mode_0       = processor_mode_0;
      next_system_clock_control_0 = system_clock_control_0;
      next_chip_select_control    = chip_select_control;
      next_serial0_mode           = serial0_mode;
      next_serial0_control_0      = serial0_control_0;
      next_port4_direction        = port4_direction;
      next_port5_direction        = port5_direction;
      next_port6_direction        = port6_direction;
      next_pullup_control_1       = pullup_control_1;
      next_port4_data             = port4_data;
      next_port5_data             = port5_data;
      next_port6_data             = port6_data;
      next_reg_rdata              = 8'h00;
      if (reg_wr) begin
         case (reg_addr)
            pin_mux_pkg::OFS_PROC_MODE:   next_processor_mode_0 = reg_wdata;
            pin_mux_pkg::OFS_SYS_CLOCK:   next_system_clock_control_0 = reg_wdata;
            pin_mux_pkg::OFS_CHIP_SELECT: next_chip_select_control = reg_wdata;
            pin_mux_pkg::OFS_SER_MODE:    next_serial0_mode = reg_wdata;
            pin_mux_pkg::OFS_SER_CTRL:    next_serial0_control_0 = reg_wdata;
            pin_mux_pkg::OFS_P4_DIR:      next_port4_direction = reg_wdata;
            pin_mux_pkg::OFS_P5_DIR:      next_port5_direction = reg_wdata;
            pin_mux_pkg::OFS_P6_DIR:      next_port6_direction = reg_wdata;
            pin_mux_pkg::OFS_PULLUP:      next_pullup_control_1 = reg_wdata;
            pin_mux_pkg::OFS_P4_DATA:     next_port4_data = reg_wdata;
            pin_mux_pkg::OFS_P5_DATA:     next_port5_data = reg_wdata;
            pin_mux_pkg::OFS_P6_DATA:     next_port6_data = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            pin_mux_pkg::OFS_PROC_MODE:   next_reg_rdata = processor_mode_0;
            pin_mux_pkg::OFS_SYS_CLOCK:   next_reg_rdata = system_clock_control_0;
            pin_mux_pkg::OFS_CHIP_SELECT: next_reg_rdata = chip_select_control;
            pin_mux_pkg::OFS_SER_MODE:    next_reg_rdata = serial0_mode;
            pin_mux_pkg::OFS_SER_CTRL:    next_reg_rdata = serial0_control_0;
            pin_mux_pkg::OFS_P4_DIR:      next_reg_rdata = port4_direction;
            pin_mux_pkg::OFS_P5_DIR:      next_reg_rdata = port5_direction;
            pin_mux_pkg::OFS_P6_DIR:      next_reg_rdata = port6_direction;
            pin_mux_pkg::OFS_PULLUP:      next_reg_rdata = pullup_control_1;
            pin_mux_pkg::OFS_P4_DATA:     next_reg_rdata = {read_v[1:0], port4_data[5:0]};
            pin_mux_pkg::OFS_P5_DATA:     next_reg_rdata = read_v[9:2];
            pin_mux_pkg::OFS_P6_DATA:     next_reg_rdata = {port6_data[7:2], read_v[11:10]};
            default:                      next_reg_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         processor_mode_0       <= pin_mux_pkg::REG_RESET;
         system_clock_control_0 <= pin_mux_pkg::REG_RESET;
         chip_select_control    <= pin_mux_pkg::REG_RESET;
         serial0_mode           <= pin_mux_pkg::REG_RESET;
         serial0_control_0      <= pin_mux_pkg::REG_RESET;
         port4_direction        <= pin_mux_pkg::REG_RESET;
         port5_direction        <= pin_mux_pkg::REG_RESET;
         port6_direction        <= pin_mux_pkg::REG_RESET;
         pullup_control_1       <= pin_mux_pkg::REG_RESET;
         port4_data             <= pin_mux_pkg::REG_RESET;
         port5_data             <= pin_mux_pkg::REG_RESET;
         port6_data             <= pin_mux_pkg::REG_RESET;
         reg_rdata              <= 8'h00;
      end else begin
         processor_mode_0       <= next_processor_mode_0;
         system_clock_control_0 <= next_system_clock_control_0;
         chip_select_control    <= next_chip_select_control;
         serial0_mode           <= next_serial0_mode;
         serial0_control_0      <= next_serial0_control_0;
         port4_direction        <= next_port4_direction;
         port5_direction        <= next_port5_direction;
         port6_direction        <= next_port6_direction;
         pullup_control_1       <= next_pullup_control_1;
         port4_data             <= next_port4_data;
         port5_data             <= next_port5_data;
         port6_data             <= next_port6_data;
         reg_rdata              <= next_reg_rdata;
      end
   end

   // Function decode
   always_comb begin
      ext_bus = processor_mode_0[pin_mux_pkg::PM_MODE_LO];
      gp_mode = ~processor_mode_0[pin_mux_pkg::PM_MODE_LO] & ~processor_mode_0[pin_mux_pkg::PM_MODE_HI];
      ser_on = |serial0_mode[pin_mux_pkg::SM_MODE_HI:0];
      ser_async = serial0_mode[pin_mux_pkg::SM_ASYNC];
      ser_clk_ext = serial0_mode[pin_mux_pkg::SM_CLK_EXT];
      flow_on = ser_on & ~serial0_control_0[pin_mux_pkg::SC_FLOW_OFF];
      clk_in_fn = ser_on & ~ser_async & ser_clk_ext & ~dir_v[pin_mux_pkg::PIN_SER_CLOCK];
      flow_in_fn = flow_on & ~serial0_control_0[pin_mux_pkg::SC_FLOW_SEL]
                   & ~dir_v[pin_mux_pkg::PIN_FLOW];
      take    = '0;
      per_oe  = '0;
      per_out = '0;
      // Serial clock: async character mode leaves the pin to the port
      if (ser_on && !ser_async) begin
         if (!ser_clk_ext) begin
            take[pin_mux_pkg::PIN_SER_CLOCK]    = 1'b1;
            per_oe[pin_mux_pkg::PIN_SER_CLOCK]  = 1'b1;
            per_out[pin_mux_pkg::PIN_SER_CLOCK] = serial0_clock_internal;
         end else if (clk_in_fn) begin
            take[pin_mux_pkg::PIN_SER_CLOCK] = 1'b1;
         end
      end
      if (flow_on && serial0_control_0[pin_mux_pkg::SC_FLOW_SEL]) begin
         take[pin_mux_pkg::PIN_FLOW]    = 1'b1;
         per_oe[pin_mux_pkg::PIN_FLOW]  = 1'b1;
         per_out[pin_mux_pkg::PIN_FLOW] = serial0_request_to_send;
      end else if (flow_in_fn) begin
         take[pin_mux_pkg::PIN_FLOW] = 1'b1;
      end
      if (ext_bus) begin
         take[pin_mux_pkg::PIN_ADDR_LATCH]    = 1'b1;
         per_oe[pin_mux_pkg::PIN_ADDR_LATCH]  = 1'b1;
         per_out[pin_mux_pkg::PIN_ADDR_LATCH] = address_latch;
         take[pin_mux_pkg::PIN_HOLD_REQ]      = 1'b1;
         take[pin_mux_pkg::PIN_HOLD_ACK]      = 1'b1;
         per_oe[pin_mux_pkg::PIN_HOLD_ACK]    = 1'b1;
         per_out[pin_mux_pkg::PIN_HOLD_ACK]   = bus_hold_acknowledge;
         take[pin_mux_pkg::PIN_READ]          = 1'b1;
         per_oe[pin_mux_pkg::PIN_READ]        = 1'b1;
         per_out[pin_mux_pkg::PIN_READ]       = read_strobe;
         // Ready input owns the clock output pin in bus modes
         take[pin_mux_pkg::PIN_CLOCK_OUT]     = 1'b1;
         if (!processor_mode_0[pin_mux_pkg::PM_BUSCLK_OFF]) begin
            take[pin_mux_pkg::PIN_BUS_CLOCK]    = 1'b1;
            per_oe[pin_mux_pkg::PIN_BUS_CLOCK]  = 1'b1;
            per_out[pin_mux_pkg::PIN_BUS_CLOCK] = bus_clock;
         end
         take[pin_mux_pkg::PIN_UPPER_BYTE]   = 1'b1;
         per_oe[pin_mux_pkg::PIN_UPPER_BYTE] = 1'b1;
         take[pin_mux_pkg::PIN_LOW_WRITE]    = 1'b1;
         per_oe[pin_mux_pkg::PIN_LOW_WRITE]  = 1'b1;
         if (processor_mode_0[pin_mux_pkg::PM_WR_MODE]) begin
            per_out[pin_mux_pkg::PIN_UPPER_BYTE] = upper_byte_write_strobe;
            per_out[pin_mux_pkg::PIN_LOW_WRITE]  = lower_byte_write_strobe;
         end else begin
            per_out[pin_mux_pkg::PIN_UPPER_BYTE] = byte_high_enable;
            per_out[pin_mux_pkg::PIN_LOW_WRITE]  = single_write_strobe;
         end
         if (chip_select_control[pin_mux_pkg::CSC_THREE]) begin
            take[pin_mux_pkg::PIN_SELECT_THREE]    = 1'b1;
            per_oe[pin_mux_pkg::PIN_SELECT_THREE]  = 1'b1;
            per_out[pin_mux_pkg::PIN_SELECT_THREE] = chip_select_three;
         end
         if (chip_select_control[pin_mux_pkg::CSC_TWO]) begin
            take[pin_mux_pkg::PIN_SELECT_TWO]    = 1'b1;
            per_oe[pin_mux_pkg::PIN_SELECT_TWO]  = 1'b1;
            per_out[pin_mux_pkg::PIN_SELECT_TWO] = chip_select_two;
         end
      end else if (gp_mode && (system_clock_control_0[pin_mux_pkg::SCC_OUT_HI:pin_mux_pkg::SCC_OUT_LO] != 2'h0))
      begin
         take[pin_mux_pkg::PIN_CLOCK_OUT]    = 1'b1;
         per_oe[pin_mux_pkg::PIN_CLOCK_OUT]  = 1'b1;
         per_out[pin_mux_pkg::PIN_CLOCK_OUT] = clock_output_source;
      end
      // Peripheral inputs see the filtered pin only while they own it
      next_clock_external = clk_in_fn & ~ser_async & pin_level[pin_mux_pkg::PIN_SER_CLOCK];
      next_clear_to_send  = flow_in_fn & pin_level[pin_mux_pkg::PIN_FLOW];
      next_hold_request   = ext_bus & pin_level[pin_mux_pkg::PIN_HOLD_REQ];
      next_bus_ready      = ext_bus & pin_level[pin_mux_pkg::PIN_CLOCK_OUT];
   end

   for (genvar i = 0; i < N; i++) begin : g_pin
      pin_cell u_cell (
         .dir       (dir_v[i]),
         .latch     (latch_v[i]),
         .pullup_bit(pu_v[i]),
         .take      (take[i]),
         .per_oe    (per_oe[i]),
         .per_out   (per_out[i]),
         .out       (cell_out[i]),
         .oe        (cell_oe[i]),
         .pull      (cell_pull[i])
      );
   end

   // Pads and peripheral inputs are registered, costing one cycle of latency
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pad_out                <= '0;
         pad_oe                 <= '0;
         pad_pullup             <= '0;
         serial0_clock_external <= 1'b0;
         serial0_clear_to_send  <= 1'b0;
         hold_request           <= 1'b0;
         bus_ready              <= 1'b0;
      end else begin
         pad_out                <= cell_out;
         pad_oe                 <= cell_oe;
         pad_pullup             <= cell_pull;
         serial0_clock_external <= next_clock_external;
         serial0_clear_to_send  <= next_clear_to_send;
         hold_request           <= next_hold_request;
         bus_ready              <= next_bus_ready;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_clock_pin_out: assert property (
      ser_on && !ser_async && !ser_clk_ext
      |=> pad_oe[pin_mux_pkg::PIN_SER_CLOCK] && pad_out[pin_mux_pkg::PIN_SER_CLOCK] == $past(serial0_clock_internal))
      else $error("serial clock pin not driving internal clock");

   a_clock_pin_in: assert property (
      clk_in_fn |=> !pad_oe[pin_mux_pkg::PIN_SER_CLOCK])
      else $error("serial clock input pin is driven");

   a_async_port: assert property (
      ser_on && ser_async
      |=> pad_oe[pin_mux_pkg::PIN_SER_CLOCK] == $past(dir_v[pin_mux_pkg::PIN_SER_CLOCK]))
      else $error("serial clock pin not a port in async mode");

   a_serial_off: assert property (
      !ser_on |=> pad_oe[pin_mux_pkg::PIN_FLOW] == $past(dir_v[pin_mux_pkg::PIN_FLOW])
                  && pad_oe[pin_mux_pkg::PIN_SER_CLOCK] == $past(dir_v[pin_mux_pkg::PIN_SER_CLOCK]))
      else $error("serial pins taken while serial off");

   a_port_drive: assert property (
      gp_mode && dir_v[pin_mux_pkg::PIN_READ]
      |=> pad_oe[pin_mux_pkg::PIN_READ] && pad_out[pin_mux_pkg::PIN_READ] == $past(latch_v[pin_mux_pkg::PIN_READ]))
      else $error("port pin not driving its latch");

   a_pullup_gate: assert property (
      gp_mode && !dir_v[pin_mux_pkg::PIN_ADDR_LATCH]
      |=> pad_pullup[pin_mux_pkg::PIN_ADDR_LATCH] == $past(pullup_control_1[pin_mux_pkg::PU_P54]))
      else $error("pull-up does not follow group bit");

   a_pull_not_out: assert property (
      (pad_pullup & pad_oe) == '0)
      else $error("pull-up on a driven pin");

   a_flow_request: assert property (
      flow_on && serial0_control_0[pin_mux_pkg::SC_FLOW_SEL]
      |=> pad_oe[pin_mux_pkg::PIN_FLOW] && pad_out[pin_mux_pkg::PIN_FLOW] == $past(serial0_request_to_send))
      else $error("flow pin not driving request");

   a_bus_ctrl: assert property (
      ext_bus |=> pad_oe[pin_mux_pkg::PIN_ADDR_LATCH] && pad_oe[pin_mux_pkg::PIN_HOLD_ACK]
                  && pad_oe[pin_mux_pkg::PIN_READ] && !pad_oe[pin_mux_pkg::PIN_HOLD_REQ])
      else $error("bus control pins not taken");

   a_bus_clock: assert property (
      ext_bus |=> pad_oe[pin_mux_pkg::PIN_BUS_CLOCK] == !$past(processor_mode_0[pin_mux_pkg::PM_BUSCLK_OFF]))
      else $error("bus clock pin enable wrong");

   a_upper_byte: assert property (
      ext_bus && processor_mode_0[pin_mux_pkg::PM_WR_MODE]
      |=> pad_out[pin_mux_pkg::PIN_UPPER_BYTE] == $past(upper_byte_write_strobe))
      else $error("upper byte pin wrong source");

   a_lower_write: assert property (
      ext_bus && !processor_mode_0[pin_mux_pkg::PM_WR_MODE]
      |=> pad_out[pin_mux_pkg::PIN_LOW_WRITE] == $past(single_write_strobe))
      else $error("lower write pin wrong source");

   a_chip_select: assert property (
      ext_bus && chip_select_control[pin_mux_pkg::CSC_THREE]
      |=> pad_oe[pin_mux_pkg::PIN_SELECT_THREE] && pad_out[pin_mux_pkg::PIN_SELECT_THREE] == $past(chip_select_three))
      else $error("chip select three pin not driven");
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the serial and bus pin function select block
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %0t %h %h", $time, g, e); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, wr, rd;
   logic [9:0]  addr;
   logic [7:0]  wd, rdata;
   logic [11:0] pin, pout, poe, ppu;
   logic [12:0] per;
   logic        ck_ext, cts, hreq, rdy;
   int          n_errors, compares;
   // Driven levels differ between the alternatives of a pin so a wrong choice shows
   pin_function_select DUT (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
      .reg_rd(rd), .reg_rdata(rdata), .serial0_clock_internal(per[0]), .serial0_request_to_send(per[1]),
      .bus_clock(per[2]), .address_latch(per[3]), .bus_hold_acknowledge(per[4]), .read_strobe(per[5]),
      .byte_high_enable(per[6]), .upper_byte_write_strobe(per[7]), .single_write_strobe(per[8]),
      .lower_byte_write_strobe(per[9]), .chip_select_three(per[10]), .chip_select_two(per[11]),
      .clock_output_source(per[12]), .pad_in(pin), .pad_out(pout), .pad_oe(poe), .pad_pullup(ppu),
      .serial0_clock_external(ck_ext), .serial0_clear_to_send(cts), .hold_request(hreq), .bus_ready(rdy));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic wreg(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [9:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      `CHK(rdata, e)
   endtask
   // Long enough for the pad synchroniser and the registered pad outputs
   task automatic settle;
      repeat (8) @(posedge clk);
      #1;
   endtask
   task automatic end_sim;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #20us;
      n_errors++;
      end_sim();
   end
   initial begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 10'h000;
      wd = 8'h00;
      pin = 12'h0f0;
      per = 13'h1d7f;
      n_errors = 0;
      compares = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rreg(10'h004, 8'h00);
      rreg(10'h100, 8'h00);
      // Wait-insert bits stay 0 so the ready input may be used
      wreg(10'h008, 8'h0c);
      wreg(10'h3eb, 8'hff);
      wreg(10'h3e9, 8'ha5);
      wreg(10'h3fd, 8'h0c);
      settle();
      `CHK(poe[9:0], 10'h3fc)
      `CHK(pout[9:2], 8'ha5)
      `CHK(ppu[9:2], 8'h00)
      wreg(10'h3eb, 8'h00);
      settle();
      `CHK(poe[9:2], 8'h00)
      `CHK(ppu[9:2], 8'hff)
      rreg(10'h3e9, 8'h3c);
      // Clock output function of the ready pin, only in single-chip mode
      wreg(10'h006, 8'h01);
      settle();
      `CHK({poe[9], pout[9]}, 2'b11)
      wreg(10'h004, 8'h01);
      pin <= 12'he80;
      rreg(10'h004, 8'h01);
      settle();
      `CHK(poe[9:0], 10'h17f)
      `CHK(pout[9:0] & poe[9:0], 10'h17f)
      `CHK({hreq, rdy}, 2'b11)
      wreg(10'h004, 8'h05);
      settle();
      `CHK(pout[3:2], 2'b00)
      wreg(10'h3a0, 8'h01);
      wreg(10'h3a4, 8'h04);
      settle();
      `CHK(poe[11:10], 2'b11)
      `CHK(pout[11:10], 2'b11)
      wreg(10'h3a4, 8'h00);
      wreg(10'h3a0, 8'h09);
      settle();
      `CHK(poe[11:10], 2'b00)
      `CHK({ck_ext, cts}, 2'b11)
      wreg(10'h3a0, 8'h0d);
      wreg(10'h3ee, 8'h02);
      settle();
      `CHK({poe[11], pout[11], ck_ext}, 3'b100)
      wreg(10'h3a4, 8'h04);
      wreg(10'h3a0, 8'h00);
      settle();
      `CHK({poe[10], cts}, 2'b00)
      end_sim();
   end
endmodule
`default_nettype wire
